// ### include/sslpd_pkg.sv
// Constants, field layouts and register map of the synthesizer serial load and phase detect block.
// Assumes a single 100 MHz core clock; every pin is synchronised before use.
package sslpd_pkg;

    localparam int unsigned WORD_W = 20;
    localparam int unsigned ENH_W = 8;
    localparam int unsigned APB_AW = 8;

    // Main counter, swallow counter and reference counter fields of a frequency word.
    typedef struct packed {
        logic rsvd;
        logic [5:0] r;
        logic [3:0] a;
        logic [8:0] m;
    } sslpd_word_t;

    // Enhancement register layout.
    typedef struct packed {
        logic [3:0] spare;
        logic hold;
        logic swap;
        logic [1:0] dout_sel;
    } sslpd_enh_t;

    localparam logic [1:0] DOUT_OFF = 2'h0;
    localparam logic [1:0] DOUT_NV = 2'h1;
    localparam logic [1:0] DOUT_REF = 2'h2;
    localparam logic [1:0] DOUT_VCO = 2'h3;

    localparam logic [3:0] PRESC_LOW = 4'ha;
    localparam logic [3:0] PRESC_HIGH = 4'hb;

    localparam logic [WORD_W-1:0] WORD_RST = 20'h00000;
    localparam logic [ENH_W-1:0] ENH_RST = 8'h00;

    // Synchronised pin bit positions.
    localparam int unsigned PIN_SCLK = 0;
    localparam int unsigned PIN_SDATA = 1;
    localparam int unsigned PIN_SECLD = 2;
    localparam int unsigned PIN_ENHWR = 3;
    localparam int unsigned PIN_FREQ_WORD_SELECT = 4;
    localparam int unsigned PIN_NVLD = 5;
    localparam int unsigned PIN_NVSEL = 6;
    localparam int unsigned PIN_EXTN = 7;
    localparam int unsigned PIN_REF = 8;
    localparam int unsigned PIN_VCO = 9;
    localparam int unsigned PIN_N = 10;
    // Pull-up pins idle high, the rest idle low.
    localparam logic [PIN_N-1:0] PIN_RST = 10'h0c0;

    localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_PRIMARY = 8'h08;
    localparam logic [APB_AW-1:0] ADDR_SECONDARY = 8'h0c;
    localparam logic [APB_AW-1:0] ADDR_NVIMG = 8'h10;
    localparam logic [APB_AW-1:0] ADDR_ENH = 8'h14;
    localparam int unsigned CTRL_HOLD = 0;
    localparam int unsigned STAT_LOCK = 0;
    localparam int unsigned STAT_CAP = 1;
    localparam int unsigned STAT_NVACT = 2;

endpackage

// ### hw/sslpd_sync.sv
// Bank of two-flop synchronisers for asynchronous pins.
// Assumes the reset value of each bit matches the idle level of its pin.
`timescale 1ns/1ps
module sslpd_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // sslpd_sync

// ### hw/sslpd_core.sv
// Serial load port, frequency word storage, dual-modulus counters and phase detector.
// Assumes all pins are asynchronous to clk_i and slow compared with it; APB is on clk_i.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module sslpd_core (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic sec_load_i,
    input wire logic enh_wr_i,
    input wire logic freq_word_select_i,
    input wire logic nv_load_ctrl_i,
    input wire logic nv_select_ctrl_i,
    input wire logic extended_mode_n_i,
    input wire logic reference_input_i,
    input wire logic vco_input_i,
    output logic phase_up_n_o,
    output logic phase_down_n_o,
    output logic filter_cap_node_o,
    output logic lock_indicator_o,
    output logic lock_indicator_oe_o,
    output logic aux_dout_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [sslpd_pkg::APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    import sslpd_pkg::*;

    logic [PIN_N-1:0] pin_s;
    logic [PIN_N-1:0] pin_prev_q;
    sslpd_word_t pri_q, sec_q, nv_q, active_word;
    sslpd_enh_t enh_q, enh_eff;
    logic [3:0] presc_cnt_q, presc_mod;
    logic [3:0] a_cnt_q;
    logic [8:0] m_cnt_q;
    logic [5:0] ref_cnt_q;
    logic up_q, down_q, cap_q, dout_q, ctrl_hold_q;
    logic [31:0] prdata_q;
    logic err_q;

    sslpd_sync #(
        .WIDTH(PIN_N),
        .RST_VAL(PIN_RST)
    ) u_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .async_i({vco_input_i, reference_input_i, extended_mode_n_i, nv_select_ctrl_i,
                  nv_load_ctrl_i, freq_word_select_i, enh_wr_i, sec_load_i, sdata_i, sclk_i}),
        .sync_o(pin_s)
    );

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_prev_q <= PIN_RST;
        end else begin
            pin_prev_q <= pin_s;
        end
    end

    // Rising edge of one synchronised pin, judged against its value one clock earlier.
    function automatic logic pin_rise(input logic [PIN_N-1:0] now, input logic [PIN_N-1:0] prev,
                                      input int unsigned idx);
        return now[idx] & ~prev[idx];
    endfunction

    wire sclk_rise = pin_rise(pin_s, pin_prev_q, PIN_SCLK);
    wire sec_rise = pin_rise(pin_s, pin_prev_q, PIN_SECLD);
    wire ref_rise = pin_rise(pin_s, pin_prev_q, PIN_REF);
    wire vco_rise = pin_rise(pin_s, pin_prev_q, PIN_VCO);
    wire sdat = pin_s[PIN_SDATA];
    wire ext_en = ~pin_s[PIN_EXTN];

    // Serial target: enhancement write enable wins, then image load, else primary.
    wire tgt_enh = pin_s[PIN_ENHWR];
    wire tgt_nv = ~pin_s[PIN_ENHWR] & pin_s[PIN_NVLD];
    wire tgt_pri = ~pin_s[PIN_ENHWR] & ~pin_s[PIN_NVLD];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pri_q <= WORD_RST;
            nv_q <= WORD_RST;
            enh_q <= ENH_RST;
        end else if (sclk_rise) begin
            if (tgt_pri) pri_q <= {sdat, pri_q[WORD_W-1:1]};
            if (tgt_nv) nv_q <= {sdat, nv_q[WORD_W-1:1]};
            if (tgt_enh) enh_q <= {sdat, enh_q[ENH_W-1:1]};
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sec_q <= WORD_RST;
        end else if (sec_rise) begin
            sec_q <= pri_q;
        end
    end

    // Image word drives the counters only when both selects are high and no image load is open.
    wire use_nv = pin_s[PIN_FREQ_WORD_SELECT] & pin_s[PIN_NVSEL] & ~pin_s[PIN_NVLD];
    assign active_word = use_nv ? nv_q : sec_q;
    assign enh_eff = ext_en ? enh_q : sslpd_enh_t'(ENH_RST);

    wire hold = ctrl_hold_q | enh_eff.hold;

    // Dual-modulus prescaler: eleven while swallow count remains, ten afterwards.
    assign presc_mod = (a_cnt_q != 4'h0) ? PRESC_HIGH : PRESC_LOW;
    wire presc_tick = vco_rise & (presc_cnt_q == presc_mod - 4'h1);
    wire divided_vco_freq = presc_tick & (m_cnt_q == active_word.m);
    wire divided_ref_freq = ref_rise & (ref_cnt_q == active_word.r);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            presc_cnt_q <= 4'h0;
            m_cnt_q <= 9'h000;
            a_cnt_q <= 4'h0;
            ref_cnt_q <= 6'h00;
        end else if (hold) begin
            presc_cnt_q <= 4'h0;
            m_cnt_q <= 9'h000;
            a_cnt_q <= active_word.a;
            ref_cnt_q <= 6'h00;
        end else begin
            if (vco_rise) presc_cnt_q <= presc_tick ? 4'h0 : presc_cnt_q + 4'h1;
            if (divided_vco_freq) begin
                m_cnt_q <= 9'h000;
                a_cnt_q <= active_word.a;
            end else if (presc_tick) begin
                m_cnt_q <= m_cnt_q + 9'h001;
                if (a_cnt_q != 4'h0) a_cnt_q <= a_cnt_q - 4'h1;
            end
            if (ref_rise) ref_cnt_q <= divided_ref_freq ? 6'h00 : ref_cnt_q + 6'h01;
        end
    end

    // Tri-state phase detector; in extended mode the swap bit exchanges the roles of the two inputs.
    wire pd_ref = enh_eff.swap ? divided_vco_freq : divided_ref_freq;
    wire pd_fb = enh_eff.swap ? divided_ref_freq : divided_vco_freq;
    wire up_set = up_q | pd_ref;
    wire down_set = down_q | pd_fb;
    wire up_d = up_set & ~down_set & ~hold;
    wire down_d = down_set & ~up_set & ~hold;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            up_q <= 1'b0;
            down_q <= 1'b0;
            cap_q <= 1'b0;
        end else begin
            up_q <= up_d;
            down_q <= down_d;
            cap_q <= ~((~up_d) & (~down_d));
        end
    end

    assign phase_up_n_o = ~up_q;
    assign phase_down_n_o = ~down_q;
    assign filter_cap_node_o = cap_q;
    assign lock_indicator_o = 1'b0;
    assign lock_indicator_oe_o = cap_q;

    // Auxiliary output; with image readback selected in extended mode, the image word shifts out bit 0 first on each serial edge while an image load is open.
    wire dout_d = !ext_en ? 1'b0 :
                  (enh_q.dout_sel == DOUT_NV) ? nv_q[0] :
                  (enh_q.dout_sel == DOUT_REF) ? divided_ref_freq :
                  (enh_q.dout_sel == DOUT_VCO) ? divided_vco_freq : 1'b0;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dout_q <= 1'b0;
        end else begin
            dout_q <= dout_d;
        end
    end

    assign aux_dout_o = dout_q;

    // APB slave, zero wait states; read data and error are latched in the setup cycle.
    wire setup = psel_i & ~penable_i;
    wire wr_en = psel_i & penable_i & pwrite_i;
    wire hit_ctrl = paddr_i == ADDR_CTRL;
    wire hit_stat = paddr_i == ADDR_STATUS;
    wire hit_pri = paddr_i == ADDR_PRIMARY;
    wire hit_sec = paddr_i == ADDR_SECONDARY;
    wire hit_nv = paddr_i == ADDR_NVIMG;
    wire hit_enh = paddr_i == ADDR_ENH;
    wire hit_any = hit_ctrl | hit_stat | hit_pri | hit_sec | hit_nv | hit_enh;
    wire [31:0] stat_word = {29'h0, use_nv, cap_q, ~cap_q};
    wire [31:0] rd_mux = hit_ctrl ? {31'h0, ctrl_hold_q} :
                         hit_stat ? stat_word :
                         hit_pri ? {12'h000, pri_q} :
                         hit_sec ? {12'h000, sec_q} :
                         hit_nv ? {12'h000, nv_q} :
                         hit_enh ? {24'h000000, enh_q} : 32'h00000000;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_q <= 32'h00000000;
            err_q <= 1'b0;
            ctrl_hold_q <= 1'b0;
        end else begin
            if (setup) begin
                prdata_q <= pwrite_i ? 32'h00000000 : rd_mux;
                err_q <= ~hit_any;
            end
            if (wr_en && hit_ctrl) ctrl_hold_q <= pwdata_i[CTRL_HOLD];
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & err_q;

    a_sec_copy_word: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sec_rise |=> sec_q == $past(pri_q)) else $error("secondary word not copied");
    a_shift_lsb_first: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sclk_rise && tgt_pri |=> pri_q == {$past(sdat), $past(pri_q[WORD_W-1:1])})
        else $error("primary shift wrong");
    a_shift_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !sclk_rise |=> $stable(pri_q) && $stable(nv_q) && $stable(enh_q))
        else $error("serial words moved without a clock edge");
    a_enh_write_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sclk_rise && !tgt_enh |=> $stable(enh_q)) else $error("enhancement written while gated");
    a_nv_readback: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ext_en && enh_q.dout_sel == DOUT_NV |=> aux_dout_o == $past(nv_q[0]))
        else $error("image readback bit wrong");
    a_aux_disabled: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !ext_en |=> !aux_dout_o) else $error("aux output driven while disabled");
    a_enh_mode_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !ext_en |-> enh_eff == sslpd_enh_t'(ENH_RST)) else $error("enhancement bits leak");
    a_cap_nand_pd: assert property (@(posedge clk_i) disable iff (!rstn_i)
        filter_cap_node_o == !(phase_up_n_o && phase_down_n_o)) else $error("filter node wrong");
    a_lock_open_drain: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !lock_indicator_o && (lock_indicator_oe_o == filter_cap_node_o))
        else $error("lock output wrong");
    a_down_on_lead: assert property (@(posedge clk_i) disable iff (!rstn_i)
        pd_fb && !pd_ref && !up_q && !hold |=> !phase_down_n_o && phase_up_n_o)
        else $error("down pulse missing");
    a_up_on_lead: assert property (@(posedge clk_i) disable iff (!rstn_i)
        pd_ref && !pd_fb && !down_q && !hold |=> !phase_up_n_o && phase_down_n_o)
        else $error("up pulse missing");
    a_presc_eleven: assert property (@(posedge clk_i) disable iff (!rstn_i)
        vco_rise && !hold && a_cnt_q != 4'h0 && presc_cnt_q == PRESC_LOW - 4'h1
        |=> presc_cnt_q == PRESC_LOW) else $error("prescaler not dividing by eleven");

    // Serial port: each step of a shift into the image or enhancement word, and the secondary word between strobes.
    sequence s_nv_edge;
        sclk_rise && tgt_nv;
    endsequence
    sequence s_enh_edge;
        sclk_rise && tgt_enh;
    endsequence

    a_nv_shift_lsb: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_nv_edge |=> nv_q == {$past(sdat), $past(nv_q[WORD_W-1:1])})
        else $error("image shift wrong");
    a_nv_shift_out: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_nv_edge ##1 ext_en && enh_q.dout_sel == DOUT_NV |=> aux_dout_o == $past(nv_q[1], 2))
        else $error("image word not shifted out");
    a_enh_shift_lsb: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_enh_edge |=> enh_q == {$past(sdat), $past(enh_q[ENH_W-1:1])})
        else $error("enhancement shift wrong");
    a_sec_hold_word: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !sec_rise |=> $stable(sec_q)) else $error("secondary word moved without a strobe");

    // Divider and detector: modulus ten once the swallow count is spent, reload at each divided pulse, detector quiet after a pulse pair or in hold.
    a_presc_ten: assert property (@(posedge clk_i) disable iff (!rstn_i)
        vco_rise && !hold && a_cnt_q == 4'h0 && presc_cnt_q == PRESC_LOW - 4'h1
        |=> presc_cnt_q == 4'h0) else $error("prescaler not dividing by ten");
    a_fb_reload: assert property (@(posedge clk_i) disable iff (!rstn_i)
        divided_vco_freq && !hold |=> m_cnt_q == 9'h000 && a_cnt_q == $past(active_word.a))
        else $error("feedback counters not reloaded");
    a_ref_restart: assert property (@(posedge clk_i) disable iff (!rstn_i)
        divided_ref_freq && !hold |=> ref_cnt_q == 6'h00)
        else $error("reference counter not restarted");
    a_both_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        pd_ref && pd_fb |=> phase_up_n_o && phase_down_n_o)
        else $error("detector not cleared by a pulse pair");
    a_hold_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
        hold |=> phase_up_n_o && phase_down_n_o) else $error("detector active during hold");

    // Auxiliary output: divided pulses appear one clock late when selected.
    a_aux_ref_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ext_en && enh_q.dout_sel == DOUT_REF |=> aux_dout_o == $past(divided_ref_freq))
        else $error("aux reference pulse wrong");
    a_aux_vco_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ext_en && enh_q.dout_sel == DOUT_VCO |=> aux_dout_o == $past(divided_vco_freq))
        else $error("aux feedback pulse wrong");
endmodule // sslpd_core

// ### verif/sslpd_ctl_model.sv
// Model of the controller that drives the three-wire serial port.
// Assumes clk_i is the core clock; one serial clock period is eight core clocks.
`timescale 1ns/1ps
module sslpd_ctl_model (
    input wire logic clk_i,
    output logic sclk_o,
    output logic sdata_o,
    output logic sec_load_o,
    output logic enh_wr_o,
    output logic nv_load_o
);
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        sec_load_o = 1'b0;
        enh_wr_o = 1'b0;
        nv_load_o = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic set_tgt(input logic extended_mode_n, input logic nv);
        enh_wr_o <= extended_mode_n;
        nv_load_o <= nv;
        wait_clk(4);
    endtask
    // The serial clock stands low between bits and frames; data moves only while it is low.
    task automatic shift_bit(input logic b);
        sdata_o <= b;
        wait_clk(4);
        sclk_o <= 1'b1;
        wait_clk(4);
        sclk_o <= 1'b0;
    endtask
    task automatic shift_word(input logic nv, input logic [19:0] w);
        set_tgt(1'b0, nv);
        for (int i = 0; i < 20; i++) begin
            shift_bit(w[i]);
        end
        sdata_o <= ~w[19];
        set_tgt(1'b0, 1'b0);
    endtask
    task automatic shift_enh(input logic [7:0] e);
        set_tgt(1'b1, 1'b0);
        for (int i = 0; i < 8; i++) begin
            shift_bit(e[i]);
        end
        sdata_o <= ~e[7];
        set_tgt(1'b0, 1'b0);
    endtask
    task automatic load_sec();
        sec_load_o <= 1'b1;
        wait_clk(4);
        sec_load_o <= 1'b0;
        wait_clk(4);
    endtask
endmodule // sslpd_ctl_model

// ### verif/sslpd_core_tb_top.sv
// Self-checking bench for the serial load and phase detect core.
// Assumes the core answers APB at once and sees pin changes a few clocks late.
`timescale 1ns/1ps
module sslpd_core_tb_top;
    import sslpd_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic sclk, sdata, sec_load, enh_wr, nv_load;
    logic freq_word_select = 1'b0;
    logic nvsel = 1'b1;
    logic mode_n = 1'b1;
    logic ref_in = 1'b0;
    logic vco_in = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, up_n, dn_n, cap, lock, lock_oe, aux, err, b;
    logic up_q = 1'b1;
    logic dn_q = 1'b1;
    logic [19:0] w, v;
    int error_cnt = 0;
    int cmp_count = 0;
    int ref_half = 0;
    int vco_half = 0;
    int tick = 0;
    int up_cnt = 0;
    int dn_cnt = 0;
    int up_base = 0;
    always #5 clk_i = ~clk_i;
    sslpd_ctl_model u_ctl (.clk_i(clk_i), .sclk_o(sclk), .sdata_o(sdata),
        .sec_load_o(sec_load), .enh_wr_o(enh_wr), .nv_load_o(nv_load));
    sslpd_core u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .sdata_i(sdata),
        .sec_load_i(sec_load), .enh_wr_i(enh_wr), .freq_word_select_i(freq_word_select),
        .nv_load_ctrl_i(nv_load), .nv_select_ctrl_i(nvsel), .extended_mode_n_i(mode_n),
        .reference_input_i(ref_in), .vco_input_i(vco_in), .phase_up_n_o(up_n),
        .phase_down_n_o(dn_n), .filter_cap_node_o(cap), .lock_indicator_o(lock),
        .lock_indicator_oe_o(lock_oe), .aux_dout_o(aux), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr));
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            error_cnt++;
            $display("wrong value at %0t: no ready", $time);
            final_report();
        end else begin
            @(posedge clk_i);
        end
    endtask
    task automatic rdchk(input logic [APB_AW-1:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, 32'h0);
        check(rd === exp && err === 1'b0, msg);
    endtask
    // Over a window, the leading input must win most phase detector pulses.
    task automatic pfd(input logic up_dom, input string msg);
        int u0;
        int d0;
        cyc(50);
        u0 = up_cnt;
        d0 = dn_cnt;
        cyc(4000);
        check(up_dom ? (up_cnt - u0 > dn_cnt - d0 + 2) : (dn_cnt - d0 > up_cnt - u0 + 2), msg);
    endtask
    always @(posedge clk_i) begin
        tick <= tick + 1;
        if (ref_half > 0 && tick % ref_half == 0) ref_in <= ~ref_in;
        if (vco_half > 0 && tick % vco_half == 0) vco_in <= ~vco_in;
    end
    always @(negedge clk_i) begin
        up_q <= up_n;
        dn_q <= dn_n;
        if (up_q === 1'b1 && up_n === 1'b0) up_cnt <= up_cnt + 1;
        if (dn_q === 1'b1 && dn_n === 1'b0) dn_cnt <= dn_cnt + 1;
        check(cap === ~(up_n & dn_n), "filter node");
        check(lock_oe === cap && (lock_oe !== 1'b1 || lock === 1'b0), "lock pin");
    end
    initial begin
        void'($urandom(15));
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 6; i++) begin
            rdchk(8'(4 * i), (i == 1) ? 32'h1 : 32'h0, "reset value");
        end
        apb(1'b0, 8'h18, 32'h0);
        check(err === 1'b1 && rd === 32'h0, "unmapped address");
        apb(1'b1, ADDR_ENH, 32'hff);
        rdchk(ADDR_ENH, 32'h0, "read-only write");
        $display("test registers done");
        w = 20'($urandom);
        b = 1'($urandom);
        u_ctl.shift_word(1'b0, w);
        rdchk(ADDR_PRIMARY, {12'h0, w}, "primary word");
        rdchk(ADDR_SECONDARY, 32'h0, "secondary early");
        u_ctl.load_sec();
        cyc(6);
        rdchk(ADDR_SECONDARY, {12'h0, w}, "secondary copy");
        u_ctl.shift_bit(b);
        cyc(6);
        rdchk(ADDR_PRIMARY, {12'h0, b, w[19:1]}, "extra bit");
        rdchk(ADDR_SECONDARY, {12'h0, w}, "secondary kept");
        v = 20'($urandom);
        u_ctl.shift_word(1'b1, v);
        rdchk(ADDR_NVIMG, {12'h0, v}, "image word");
        u_ctl.shift_enh(8'h01);
        rdchk(ADDR_ENH, 32'h01, "enhancement word");
        rdchk(ADDR_PRIMARY, {12'h0, b, w[19:1]}, "primary kept");
        mode_n <= 1'b0;
        cyc(8);
        check(aux === v[0], "aux image bit");
        u_ctl.set_tgt(1'b0, 1'b1);
        u_ctl.shift_bit(b);
        cyc(6);
        check(aux === v[1], "aux image shifted");
        u_ctl.set_tgt(1'b0, 1'b0);
        mode_n <= 1'b1;
        cyc(8);
        check(aux === 1'b0, "aux disabled");
        $display("test serial done");
        for (int i = 0; i < 8; i++) begin
            freq_word_select <= i[0];
            nvsel <= i[1];
            u_ctl.set_tgt(1'b0, i[2]);
            apb(1'b0, ADDR_STATUS, 32'h0);
            check(rd[STAT_NVACT] === (i[0] & i[1] & ~i[2]), "word select");
        end
        freq_word_select <= 1'b0;
        nvsel <= 1'b1;
        u_ctl.set_tgt(1'b0, 1'b0);
        // Main and swallow counts of one: feedback every twenty-one prescaler input edges.
        u_ctl.shift_word(1'b0, 20'h00201);
        u_ctl.load_sec();
        ref_half <= 10;
        vco_half <= 4;
        pfd(1'b1, "reference leads");
        ref_half <= 100;
        pfd(1'b0, "feedback leads");
        ref_half <= 10;
        u_ctl.shift_enh(8'h06);
        pfd(1'b1, "swap ignored");
        mode_n <= 1'b0;
        pfd(1'b0, "swap active");
        u_ctl.shift_enh(8'h07);
        pfd(1'b0, "swap with feedback out");
        mode_n <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h1);
        rdchk(ADDR_CTRL, 32'h1, "hold bit");
        cyc(20);
        up_base = up_cnt;
        cyc(1000);
        check(up_cnt == up_base && up_n === 1'b1, "hold stops detector");
        $display("test phase detector done");
        final_report();
    end
endmodule // sslpd_core_tb_top
